/* inc/gpfc_pkg.sv */
// constants, reset defaults and pad carrier type of the pin function block
package gpfc_pkg;
    localparam int          NUM_PORTS  = 5;
    localparam int          PINS       = 8;
    localparam int          FUNC_W     = 4;
    localparam int          ADDR_W     = 16;
    localparam int          PORT_LSB   = 12;
    localparam int          MASK_LSB   = 2;
    localparam int          HI_DRV_MAX = 4;
    localparam int          TRIG_PORT  = 1;
    localparam int          TRIG_PIN   = 4;
    // register offsets inside one port window
    localparam logic [11:0] OFF_DIR    = 12'h400;
    localparam logic [11:0] OFF_ISENSE = 12'h404;
    localparam logic [11:0] OFF_IBOTH  = 12'h408;
    localparam logic [11:0] OFF_IEVENT = 12'h40C;
    localparam logic [11:0] OFF_IMASK  = 12'h410;
    localparam logic [11:0] OFF_RIS    = 12'h414;
    localparam logic [11:0] OFF_MIS    = 12'h418;
    localparam logic [11:0] OFF_ICLR   = 12'h41C;
    localparam logic [11:0] OFF_AFSEL  = 12'h420;
    localparam logic [11:0] OFF_DRV2   = 12'h500;
    localparam logic [11:0] OFF_DRV4   = 12'h504;
    localparam logic [11:0] OFF_DRV8   = 12'h508;
    localparam logic [11:0] OFF_ODR    = 12'h50C;
    localparam logic [11:0] OFF_PUR    = 12'h510;
    localparam logic [11:0] OFF_PDR    = 12'h514;
    localparam logic [11:0] OFF_SLR    = 12'h518;
    localparam logic [11:0] OFF_DEN    = 12'h51C;
    localparam logic [11:0] OFF_ANALOG_MODE_BIT  = 12'h528;
    localparam logic [11:0] OFF_PCTL   = 12'h52C;
    localparam logic [11:0] OFF_DRV18  = 12'h530;
    // drive strength codes on the pad
    localparam logic [1:0]  DRV_2MA    = 2'h0;
    localparam logic [1:0]  DRV_4MA    = 2'h1;
    localparam logic [1:0]  DRV_8MA    = 2'h2;
    localparam logic [1:0]  DRV_18MA   = 2'h3;
    // per-port implemented pins and reset values, index 0 is port A
    localparam logic [7:0]  IMPL_MASK [NUM_PORTS] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h1F};
    localparam logic [7:0]  RST_AFSEL [NUM_PORTS] = '{8'h3F, 8'h0C, 8'h0F, 8'h00, 8'h00};
    localparam logic [7:0]  RST_DEN   [NUM_PORTS] = '{8'h3F, 8'h0C, 8'h0F, 8'h00, 8'h00};
    localparam logic [7:0]  RST_PUR   [NUM_PORTS] = '{8'h00, 8'h00, 8'h0F, 8'h00, 8'h00};
    localparam logic [31:0] RST_PCTL  [NUM_PORTS] = '{32'h0011_1111, 32'h0000_1100,
                                                      32'h0000_3333, 32'h0000_0000,
                                                      32'h0000_0000};
    typedef struct packed {
        logic              out;
        logic              oe;
        logic              pull_up;
        logic              pull_down;
        logic [1:0]        drive;
        logic              slew;
        logic              open_drain;
        logic              in_en;
        logic              analog_en;
        logic [FUNC_W-1:0] pin_function_code;
    } gpfc_pad_t;
endpackage

/* src/gpfc_top.sv */
// five-port pin function, pad and interrupt control with an APB register slave
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Function
// - five ports, up to 33 pins
// - registers reached over the APB port
// - output may change every second cycle
// - per-pin interrupt masking
// - edge rise/fall/both or level high/low sensing
// - address lines mask data reads and writes
// - pin event starts converter sample sequence
// - pulls, drive, slew, open drain, input enable
// - analog only when digital off, analog on
// - alternate select plus digital enable picks peripheral
// - function code chosen independently per pin
// - other pins reset to tri-stated GPIO
// - reset restores every pin default
// - serial pins reset to function code one
// - debug pins reset with pull-up, code three
// - direction selects input capture or output drive
// - address bits 9:2 mask data access
// - write one to clear register clears edge
// - unmasked trigger pin raises irq and trigger
module gpfc_top #(
    parameter int NUM_PORTS = gpfc_pkg::NUM_PORTS,
    parameter int PINS      = gpfc_pkg::PINS
) (
    // clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [gpfc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // pads
    input  wire logic [NUM_PORTS*PINS-1:0]    pad_in,
    output gpfc_pkg::gpfc_pad_t [NUM_PORTS*PINS-1:0] pad_o,
    // on-chip peripherals owning alternate functions
    input  wire logic [NUM_PORTS*PINS-1:0]    alt_out,
    input  wire logic [NUM_PORTS*PINS-1:0]    alt_oe,
    output logic      [NUM_PORTS*PINS-1:0]    alt_in,
    // events
    output logic      [NUM_PORTS-1:0]         irq,
    output logic                              adc_trigger
);
    localparam int TOT = NUM_PORTS * PINS;

    logic [7:0]  data_r  [NUM_PORTS];
    logic [7:0]  dir_r   [NUM_PORTS];
    logic [7:0]  isense_r[NUM_PORTS];
    logic [7:0]  iboth_r [NUM_PORTS];
    logic [7:0]  ievent_r[NUM_PORTS];
    logic [7:0]  imask_r [NUM_PORTS];
    logic [7:0]  ris_r   [NUM_PORTS];
    logic [7:0]  afsel_r [NUM_PORTS];
    logic [7:0]  drv2_r  [NUM_PORTS];
    logic [7:0]  drv4_r  [NUM_PORTS];
    logic [7:0]  drv8_r  [NUM_PORTS];
    logic [7:0]  drv18_r [NUM_PORTS];
    logic [7:0]  odr_r   [NUM_PORTS];
    logic [7:0]  pur_r   [NUM_PORTS];
    logic [7:0]  pdr_r   [NUM_PORTS];
    logic [7:0]  slr_r   [NUM_PORTS];
    logic [7:0]  den_r   [NUM_PORTS];
    logic [7:0]  analog_mode_bit_r [NUM_PORTS];
    logic [31:0] pctl_r  [NUM_PORTS];
    logic [7:0]  din_r   [NUM_PORTS];
    logic [7:0]  ris_nxt [NUM_PORTS];
    logic [31:0] rd_port [NUM_PORTS];
    logic        ok_port [NUM_PORTS];
    logic [3:0]  hi_cnt  [NUM_PORTS];

    logic [2:0]  port_idx;
    logic [11:0] offset;
    logic        port_ok;
    logic        hit;
    logic        setup;
    logic        access;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_mux;
    logic [5:0]  hi_total;
    logic [NUM_PORTS-1:0] irq_r;
    logic        adc_trigger_r;
    logic [TOT-1:0] alt_in_r;
    gpfc_pkg::gpfc_pad_t [TOT-1:0] pad_r;

    function automatic logic [3:0] pop8(input logic [7:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int k = 0; k < 8; k++) begin
            c = c + {3'h0, v[k]};
        end
        return c;
    endfunction

    // bus decode
    assign port_idx = paddr[14:gpfc_pkg::PORT_LSB];
    assign offset   = paddr[gpfc_pkg::PORT_LSB-1:0];
    assign port_ok  = !paddr[15] && (port_idx < 3'(NUM_PORTS)) && (paddr[1:0] == 2'h0);
    assign setup    = psel && !penable;
    assign access   = psel && penable && pready_r && !pslverr_r;

    always_comb begin
        hit    = 1'b0;
        rd_mux = 32'h0000_0000;
        hi_total = 6'h00;
        for (int q = 0; q < NUM_PORTS; q++) begin
            hi_total = hi_total + {2'h0, hi_cnt[q]};
            if (port_ok && port_idx == 3'(q)) begin
                hit    = ok_port[q];
                rd_mux = rd_port[q];
            end
        end
    end

    // zero-wait apb answer: pready in every access phase, so two cycles per transfer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup && !hit;
            prdata_r  <= (setup && !pwrite && hit) ? rd_mux : 32'h0000_0000;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            localparam logic [7:0] MSK = gpfc_pkg::IMPL_MASK[p];
            logic        wr;
            logic        rd;
            logic [7:0]  wd;
            logic [7:0]  din;
            logic [7:0]  rise;
            logic [7:0]  fall;
            logic [7:0]  edge_ev;
            logic [7:0]  lvl_ev;
            logic [7:0]  clr;
            logic [31:0] pctl_msk;
            logic [7:0]  amask;
            gpfc_pkg::gpfc_pad_t [PINS-1:0] pin_pad_r;
            logic [PINS-1:0]                pin_alt_r;

            assign wr    = access && pwrite && port_idx == 3'(p);
            assign rd    = access && !pwrite && port_idx == 3'(p);
            assign wd    = pwdata[7:0] & MSK;
            assign amask = paddr[9:gpfc_pkg::MASK_LSB];
            assign din   = pad_in[p*PINS +: 8] & den_r[p];

            always_comb begin
                pctl_msk = 32'h0000_0000;
                for (int k = 0; k < 8; k++) begin
                    pctl_msk[k*4 +: 4] = {4{MSK[k]}};
                end
            end

            // interrupt sensing
            always_comb begin
                rise    = din & ~din_r[p];
                fall    = ~din & din_r[p];
                edge_ev = (iboth_r[p] & (rise | fall))
                        | (~iboth_r[p] & ievent_r[p] & rise)
                        | (~iboth_r[p] & ~ievent_r[p] & fall);
                lvl_ev  = (ievent_r[p] & din) | (~ievent_r[p] & ~din);
                clr     = 8'h00;
                if (wr && offset == gpfc_pkg::OFF_ICLR) begin
                    clr = wd;
                end
                if (rd && offset == gpfc_pkg::OFF_RIS) begin
                    clr = 8'hFF;
                end
                // a new edge in the clearing cycle survives the clear
                ris_nxt[p] = ((isense_r[p] & lvl_ev)
                           | (~isense_r[p] & ((ris_r[p] & ~clr) | edge_ev))) & MSK;
            end

            // read side and address validity
            always_comb begin
                ok_port[p] = 1'b1;
                rd_port[p] = 32'h0000_0000;
                if (offset[11:10] == 2'h0) begin
                    rd_port[p][7:0] = ((dir_r[p] & data_r[p]) | (~dir_r[p] & din_r[p]))
                                    & amask;
                end else begin
                    case (offset)
                        gpfc_pkg::OFF_DIR:    rd_port[p][7:0] = dir_r[p];
                        gpfc_pkg::OFF_ISENSE: rd_port[p][7:0] = isense_r[p];
                        gpfc_pkg::OFF_IBOTH:  rd_port[p][7:0] = iboth_r[p];
                        gpfc_pkg::OFF_IEVENT: rd_port[p][7:0] = ievent_r[p];
                        gpfc_pkg::OFF_IMASK:  rd_port[p][7:0] = imask_r[p];
                        gpfc_pkg::OFF_RIS:    rd_port[p][7:0] = ris_r[p];
                        gpfc_pkg::OFF_MIS:    rd_port[p][7:0] = ris_r[p] & imask_r[p];
                        gpfc_pkg::OFF_ICLR:   rd_port[p][7:0] = 8'h00;
                        gpfc_pkg::OFF_AFSEL:  rd_port[p][7:0] = afsel_r[p];
                        gpfc_pkg::OFF_DRV2:   rd_port[p][7:0] = drv2_r[p];
                        gpfc_pkg::OFF_DRV4:   rd_port[p][7:0] = drv4_r[p];
                        gpfc_pkg::OFF_DRV8:   rd_port[p][7:0] = drv8_r[p];
                        gpfc_pkg::OFF_DRV18:  rd_port[p][7:0] = drv18_r[p];
                        gpfc_pkg::OFF_ODR:    rd_port[p][7:0] = odr_r[p];
                        gpfc_pkg::OFF_PUR:    rd_port[p][7:0] = pur_r[p];
                        gpfc_pkg::OFF_PDR:    rd_port[p][7:0] = pdr_r[p];
                        gpfc_pkg::OFF_SLR:    rd_port[p][7:0] = slr_r[p];
                        gpfc_pkg::OFF_DEN:    rd_port[p][7:0] = den_r[p];
                        gpfc_pkg::OFF_ANALOG_MODE_BIT:  rd_port[p][7:0] = analog_mode_bit_r[p];
                        gpfc_pkg::OFF_PCTL:   rd_port[p]      = pctl_r[p];
                        default:              ok_port[p]      = 1'b0;
                    endcase
                end
            end

            assign hi_cnt[p] = pop8(drv18_r[p]);

            // output data, masked by address bits
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    data_r[p] <= 8'h00;
                end else if (wr && offset[11:10] == 2'h0) begin
                    data_r[p] <= (data_r[p] & ~amask) | (wd & amask);
                end
            end

            // input capture for data reads and edge history
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    din_r[p] <= 8'h00;
                    ris_r[p] <= 8'h00;
                end else begin
                    din_r[p] <= din;
                    ris_r[p] <= ris_nxt[p];
                end
            end

            // configuration registers; reset values
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    dir_r[p]    <= 8'h00;
                    isense_r[p] <= 8'h00;
                    iboth_r[p]  <= 8'h00;
                    ievent_r[p] <= 8'h00;
                    imask_r[p]  <= 8'h00;
                    afsel_r[p]  <= gpfc_pkg::RST_AFSEL[p];
                    den_r[p]    <= gpfc_pkg::RST_DEN[p];
                    pur_r[p]    <= gpfc_pkg::RST_PUR[p];
                    pdr_r[p]    <= 8'h00;
                    pctl_r[p]   <= gpfc_pkg::RST_PCTL[p];
                    odr_r[p]    <= 8'h00;
                    slr_r[p]    <= 8'h00;
                    analog_mode_bit_r[p]  <= 8'h00;
                    drv2_r[p]   <= MSK;
                    drv4_r[p]   <= 8'h00;
                    drv8_r[p]   <= 8'h00;
                    drv18_r[p]  <= 8'h00;
                end else if (wr) begin
                    case (offset)
                        gpfc_pkg::OFF_DIR:    dir_r[p]    <= wd;
                        gpfc_pkg::OFF_ISENSE: isense_r[p] <= wd;
                        gpfc_pkg::OFF_IBOTH:  iboth_r[p]  <= wd;
                        gpfc_pkg::OFF_IEVENT: ievent_r[p] <= wd;
                        gpfc_pkg::OFF_IMASK:  imask_r[p]  <= wd;
                        gpfc_pkg::OFF_AFSEL:  afsel_r[p]  <= wd;
                        gpfc_pkg::OFF_ODR:    odr_r[p]    <= wd;
                        gpfc_pkg::OFF_SLR:    slr_r[p]    <= wd;
                        gpfc_pkg::OFF_DEN:    den_r[p]    <= wd;
                        gpfc_pkg::OFF_ANALOG_MODE_BIT:  analog_mode_bit_r[p]  <= wd;
                        gpfc_pkg::OFF_PCTL:   pctl_r[p]   <= pwdata & pctl_msk;
                        gpfc_pkg::OFF_PUR: begin
                            pur_r[p] <= wd;
                            pdr_r[p] <= pdr_r[p] & ~wd;
                        end
                        gpfc_pkg::OFF_PDR: begin
                            pdr_r[p] <= wd;
                            pur_r[p] <= pur_r[p] & ~wd;
                        end
                        // drive selects are one-hot per pin
                        gpfc_pkg::OFF_DRV2: begin
                            drv2_r[p]  <= drv2_r[p] | wd;
                            drv4_r[p]  <= drv4_r[p] & ~wd;
                            drv8_r[p]  <= drv8_r[p] & ~wd;
                            drv18_r[p] <= drv18_r[p] & ~wd;
                        end
                        gpfc_pkg::OFF_DRV4: begin
                            drv2_r[p]  <= drv2_r[p] & ~wd;
                            drv4_r[p]  <= drv4_r[p] | wd;
                            drv8_r[p]  <= drv8_r[p] & ~wd;
                            drv18_r[p] <= drv18_r[p] & ~wd;
                        end
                        gpfc_pkg::OFF_DRV8: begin
                            drv2_r[p]  <= drv2_r[p] & ~wd;
                            drv4_r[p]  <= drv4_r[p] & ~wd;
                            drv8_r[p]  <= drv8_r[p] | wd;
                            drv18_r[p] <= drv18_r[p] & ~wd;
                        end
                        gpfc_pkg::OFF_DRV18: begin
                            // ignored when it would exceed the high-current pad budget
                            if (hi_total - {2'h0, hi_cnt[p]} + {2'h0, pop8(drv18_r[p] | wd)}
                                    <= 6'(gpfc_pkg::HI_DRV_MAX)) begin
                                drv2_r[p]  <= drv2_r[p] & ~wd;
                                drv4_r[p]  <= drv4_r[p] & ~wd;
                                drv8_r[p]  <= drv8_r[p] & ~wd;
                                drv18_r[p] <= drv18_r[p] | wd;
                            end
                        end
                        default: ;
                    endcase
                end
            end

            // port interrupt line
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    irq_r[p] <= 1'b0;
                end else begin
                    irq_r[p] <= |(ris_nxt[p] & imask_r[p]);
                end
            end

            // pad and peripheral side, registered per pin
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_pad_r <= '0;
                    pin_alt_r <= '0;
                end else begin
                    for (int i = 0; i < PINS; i++) begin
                        automatic logic o;
                        automatic logic e;
                        automatic logic ana;
                        automatic logic alt;
                        ana = analog_mode_bit_r[p][i] && !den_r[p][i];
                        alt = afsel_r[p][i] && den_r[p][i];
                        o   = afsel_r[p][i] ? alt_out[p*PINS+i] : data_r[p][i];
                        e   = afsel_r[p][i] ? (alt && alt_oe[p*PINS+i]) : dir_r[p][i];
                        if (odr_r[p][i]) begin
                            e = e && !o;
                            o = 1'b0;
                        end
                        pin_pad_r[i].out        <= o && MSK[i];
                        pin_pad_r[i].oe         <= e && !ana && MSK[i];
                        pin_pad_r[i].pull_up    <= pur_r[p][i];
                        pin_pad_r[i].pull_down  <= pdr_r[p][i];
                        pin_pad_r[i].drive      <= drv18_r[p][i] ? gpfc_pkg::DRV_18MA :
                                                   drv8_r[p][i]  ? gpfc_pkg::DRV_8MA  :
                                                   drv4_r[p][i]  ? gpfc_pkg::DRV_4MA  :
                                                                   gpfc_pkg::DRV_2MA;
                        pin_pad_r[i].slew       <= slr_r[p][i] && drv8_r[p][i];
                        pin_pad_r[i].open_drain <= odr_r[p][i];
                        pin_pad_r[i].in_en      <= den_r[p][i];
                        pin_pad_r[i].analog_en  <= ana;
                        pin_pad_r[i].pin_function_code <= alt ? pctl_r[p][i*4 +: 4] : 4'h0;
                        pin_alt_r[i] <= alt && pad_in[p*PINS+i];
                    end
                end
            end

            // one writer per port slice of the shared pad vectors
            assign pad_r[p*PINS +: PINS]    = pin_pad_r;
            assign alt_in_r[p*PINS +: PINS] = pin_alt_r;
        end
    endgenerate

    // converter start from the trigger pin when it is an unmasked interrupt
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_trigger_r <= 1'b0;
        end else begin
            adc_trigger_r <= ris_nxt[gpfc_pkg::TRIG_PORT][gpfc_pkg::TRIG_PIN]
                          && imask_r[gpfc_pkg::TRIG_PORT][gpfc_pkg::TRIG_PIN];
        end
    end

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign pad_o       = pad_r;
    assign alt_in      = alt_in_r;
    assign irq         = irq_r;
    assign adc_trigger = adc_trigger_r;
endmodule
`default_nettype wire

/* test/gpfc_monitor.sv */
// bus and reset-default checks on the pin function block
`timescale 1ns/1ns
`default_nettype none
module gpfc_monitor (
    // clock and reset
    input wire logic                       sys_clk,
    input wire logic                       rst_n,
    // apb
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    // pads and events
    input wire gpfc_pkg::gpfc_pad_t [39:0] pad_o,
    input wire logic [4:0]                 irq,
    input wire logic                       adc_trigger
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_ACC: assert property (psel && !penable |=> pready)
        else $error("setup not answered");
    AST_RDY: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    AST_ERR: assert property (pslverr |-> pready)
        else $error("error outside access");
    AST_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    AST_TRIG: assert property (adc_trigger |-> irq[1])
        else $error("trigger without port irq");
    AST_DBG: assert property (!$past(rst_n) |=> pad_o[16].pull_up
        && pad_o[16].pin_function_code == 4'h3) else $error("debug pin default");
    AST_SER: assert property (!$past(rst_n) |=> pad_o[0].in_en
        && pad_o[0].pin_function_code == 4'h1) else $error("serial pin default");
    AST_PLAIN: assert property (!$past(rst_n) |=> pad_o[8] == '0)
        else $error("plain pin default");
    AST_ANA: assert property (pad_o[32].analog_en |-> !pad_o[32].in_en)
        else $error("analog with digital on");
endmodule
bind gpfc_top gpfc_monitor u_mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_o(pad_o),
    .irq(irq), .adc_trigger(adc_trigger)
);
`default_nettype wire

/* test/gpfc_pins.sv */
// pin-side model: resolves each pad from block drive and outside level
`timescale 1ns/1ns
`default_nettype none
module gpfc_pins (
    // block side
    input wire gpfc_pkg::gpfc_pad_t [39:0] pad_o,
    input wire logic [39:0]                ext_lvl,
    // resolved levels
    output logic [39:0]                    pad_in
);
    always_comb begin
        for (int i = 0; i < 40; i++) begin
            pad_in[i] = pad_o[i].oe ? pad_o[i].out : ext_lvl[i];
        end
    end
endmodule
`default_nettype wire

/* test/gpfc_top_tb.sv */
// self-checking bench of the pin function block
`timescale 1ns/1ns
`default_nettype none
module gpfc_top_tb;
    typedef struct packed {logic w; logic [15:0] a; logic [31:0] d;} gpfc_row_t;
    logic                           sys_clk = 0;
    logic                           rst_n = 0;
    logic                           psel = 0;
    logic                           penable = 0;
    logic                           pwrite = 0;
    logic [15:0]                    paddr = 16'h0;
    logic [31:0]                    pwdata = 32'h0, prdata, rd;
    logic                           pready, pslverr, err, adc_trigger;
    logic [39:0]                    pad_in, alt_in;
    logic [39:0]                    alt_out = 40'hFF_FFFF_FFFF;
    logic [39:0]                    alt_oe = 40'h02;
    logic [39:0]                    ext_lvl = 40'h15_0000_0000;
    logic [4:0]                     irq;
    gpfc_pkg::gpfc_pad_t [39:0]     pad_o;
    int                             num_errors = 0, n_tests = 0;
    gpfc_row_t rows [27] = '{
        '{0, 16'h0420, 32'h3F}, '{0, 16'h251C, 32'h0F}, '{0, 16'h2510, 32'h0F},
        '{0, 16'h052C, 32'h00111111}, '{0, 16'h152C, 32'h1100},
        '{0, 16'h4420, 32'h0}, '{1, 16'h1400, 32'hE3}, '{0, 16'h1400, 32'hE3},
        '{1, 16'h1098, 32'hEB}, '{0, 16'h13FC, 32'h22}, '{0, 16'h10C4, 32'h20},
        '{1, 16'h451C, 32'h1F}, '{0, 16'h43FC, 32'h15},
        '{1, 16'h3420, 32'hFF}, '{0, 16'h3420, 32'h0F},
        '{1, 16'h452C, 32'h12345}, '{0, 16'h452C, 32'h12345},
        '{1, 16'h1510, 32'h81}, '{0, 16'h1510, 32'h81},
        '{1, 16'h151C, 32'h1C}, '{1, 16'h140C, 32'h10},
        '{1, 16'h1410, 32'h10}, '{0, 16'h1410, 32'h10},
        '{1, 16'h0530, 32'h1F}, '{0, 16'h0530, 32'h0},
        '{1, 16'h0530, 32'h0F}, '{0, 16'h0530, 32'h0F}};
    gpfc_top DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_o(pad_o),
        .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in), .irq(irq),
        .adc_trigger(adc_trigger));
    gpfc_pins u_pins (.pad_o(pad_o), .ext_lvl(ext_lvl), .pad_in(pad_in));
    always #5 sys_clk = ~sys_clk;
    task stop_test;
        if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        for (int i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) begin
                rd = prdata; err = pslverr; psel <= 0; penable <= 0;
                return;
            end
        end
        num_errors++;
        stop_test();
    endtask
    task wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    initial begin
        wt(20);
        rst_n <= 1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].d);
        end
        apb(0, 16'h0600, 0); chk(32'(err), 1);
        apb(0, 16'h5400, 0); chk(32'(err), 1);
        chk(32'({pad_o[13].oe, pad_o[13].out}), 3);
        chk(32'({pad_o[1].oe, pad_o[1].out, alt_in[1]}), 7);
        ext_lvl[12] <= 1; wt(4);
        chk(32'({irq[1], adc_trigger}), 3);
        apb(1, 16'h141C, 32'h10); wt(2); chk(32'(irq[1]), 0);
        apb(1, 16'h1404, 32'h10); wt(3); chk(32'(irq[1]), 1);
        apb(1, 16'h1410, 32'h0); wt(2); chk(32'({irq[1], adc_trigger}), 0);
        apb(1, 16'h1404, 32'h14); apb(0, 16'h1414, 0); chk(rd, 32'h14);
        apb(1, 16'h1404, 32'h0); apb(1, 16'h1408, 32'h10); apb(1, 16'h141C, 32'hFF);
        ext_lvl[12] <= 0; wt(2); apb(0, 16'h1414, 0); chk(rd, 32'h10);
        apb(1, 16'h4528, 32'h1); wt(2); chk(32'(pad_o[32].analog_en), 0);
        apb(1, 16'h451C, 32'h1E); wt(2); chk(32'(pad_o[32].analog_en), 1);
        rst_n <= 0; wt(2); rst_n <= 1;
        apb(0, 16'h1400, 0); chk(rd, 0);
        apb(0, 16'h052C, 0); chk(rd, 32'h00111111);
        stop_test();
    end
endmodule
`default_nettype wire
